// file: afeogl_defs.svh
// Purpose: Offsets, field positions, masks and reset values of the AFE setting registers
// Assumes: 10-bit registers on an 8-bit register index
// Notes: Definitions only
`ifndef AFEOGL_DEFS_SVH
`define AFEOGL_DEFS_SVH

`define AFEOGL_ADDR_W 8
`define AFEOGL_DATA_W 10
`define AFEOGL_LANES 5

`define AFEOGL_OFS_CONV_MODE 8'h0F
`define AFEOGL_OFS_RED_ODD_OFFSET 8'h10
`define AFEOGL_OFS_RED_EVEN_OFFSET 8'h11
`define AFEOGL_OFS_GREEN_ODD_OFFSET 8'h12
`define AFEOGL_OFS_GREEN_EVEN_OFFSET 8'h13
`define AFEOGL_OFS_BLUE_ODD_OFFSET 8'h14
`define AFEOGL_OFS_BLUE_EVEN_OFFSET 8'h15
`define AFEOGL_OFS_LANE_CTRL 8'h16
`define AFEOGL_OFS_RED_ODD_GAIN 8'h18
`define AFEOGL_OFS_RED_EVEN_GAIN 8'h19
`define AFEOGL_OFS_GREEN_ODD_GAIN 8'h1A
`define AFEOGL_OFS_GREEN_EVEN_GAIN 8'h1B
`define AFEOGL_OFS_BLUE_ODD_GAIN 8'h1C
`define AFEOGL_OFS_BLUE_EVEN_GAIN 8'h1D

`define AFEOGL_RST_CONV_MODE 10'h049
`define AFEOGL_RST_OFFSET 10'h200
`define AFEOGL_RST_LANE_CTRL 10'h1F0
`define AFEOGL_RST_GAIN 10'h09F

`define AFEOGL_MASK_CONV_MODE 10'h0CF
`define AFEOGL_MASK_OFFSET 10'h3FF
`define AFEOGL_MASK_LANE_CTRL 10'h1F5
`define AFEOGL_MASK_GAIN 10'h3FF

`define AFEOGL_BUF_STRENGTH_HI 7
`define AFEOGL_BUF_STRENGTH_LO 6
`define AFEOGL_BIAS_HI 3
`define AFEOGL_BIAS_LO 0
`define AFEOGL_RANGE_HI 9
`define AFEOGL_RANGE_LO 8
`define AFEOGL_GAIN_HI 7
`define AFEOGL_GAIN_LO 0
`define AFEOGL_LANE_EN_HI 8
`define AFEOGL_LANE_EN_LO 4
`define AFEOGL_TEST_PATTERN_BIT 2
`define AFEOGL_EMPHASIS_BIT 0

`define AFEOGL_TEST_PATTERN_SEED 5'h15

`endif

// file: afeogl_pkg.sv
// Purpose: Types shared by the AFE setting register bank
// Assumes: Constants live in afeogl_defs.svh
// Notes: Types only
package afeogl_pkg;

  typedef enum logic [1:0] {
    AFEOGL_BUF_HALF,
    AFEOGL_BUF_UNITY,
    AFEOGL_BUF_X1P4,
    AFEOGL_BUF_X1P7
  } afeogl_buf_strength_t;

  typedef logic [9:0] afeogl_word_t;

endpackage

// file: afeogl_wr_if.sv
// Purpose: Write path from the access decoder to each storage register
// Assumes: One clock domain
// Notes: Shared by all register instances
`timescale 1ns/100ps
interface afeogl_wr_if;
  logic wrStrobe;
  logic [7:0] wrAddr;
  afeogl_pkg::afeogl_word_t wrData;

  modport source (
    output wrStrobe,
    output wrAddr,
    output wrData
  );

  modport sink (
    input wrStrobe,
    input wrAddr,
    input wrData
  );
endinterface

// file: afeogl_field_reg.sv
// Purpose: One 10-bit setting register with address match and write mask
// Assumes: Write path comes from the same clock domain
// Notes: Masked-off bits stay zero and read as zero
`timescale 1ns/100ps
module afeogl_field_reg #(
  parameter logic [7:0] ADDR = 8'h00,
  parameter afeogl_pkg::afeogl_word_t RESET_VALUE = 10'h000,
  parameter afeogl_pkg::afeogl_word_t WRITE_MASK = 10'h3FF
) (
  input wire logic clk,
  input wire logic rst,
  afeogl_wr_if.sink wr,
  output afeogl_pkg::afeogl_word_t value
);

  afeogl_pkg::afeogl_word_t value_q;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      value_q <= RESET_VALUE & WRITE_MASK;
    end else if (wr.wrStrobe && (wr.wrAddr == ADDR)) begin
      value_q <= wr.wrData & WRITE_MASK; // R10
    end
  end

  assign value = value_q;

endmodule // afeogl_field_reg

// file: afe_offset_gain_lvds_regs.sv
// Purpose: Setting register bank for buffer, bias, channel offset/gain and output lane control
// Assumes: Host register accesses arrive on clk as single-cycle strobes; video lanes on clk
// Notes: Read data is registered one cycle after the read strobe
//
// What this block does
// R01 - Converter mode bits 7:6 hold buffer strength, 01 default, four encodings.
// R02 - Host sets bias bits 3:0 to 0x9, 0xB or 0xD by clock rate.
// R03 - Six 10-bit read-write channel offset registers, each resetting to 0x200.
// R04 - Host touches offset and gain registers only while the converter clock runs.
// R05 - Six gain registers: range select bits 9:8, gain code 7:0, reset 0x09F.
// R06 - Host always writes zero to bit 0 of every gain register.
// R07 - Lane enables in bits 8:4; a cleared enable forces that lane to zero.
// R08 - Bit 2 of lane control replaces video with the test code pattern.
// R09 - Bit 0 of lane control turns on output pre-emphasis.
// R10 - Reserved bits ignore writes and read as zero.
// R11 - After reset all five lanes enabled, test pattern and pre-emphasis off.
`timescale 1ns/100ps
`include "afeogl_defs.svh"
module afe_offset_gain_lvds_regs #(
  parameter int LANES = `AFEOGL_LANES
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic regWr,
  input wire logic regRd,
  input wire logic [`AFEOGL_ADDR_W-1:0] regAddr,
  input wire logic [`AFEOGL_DATA_W-1:0] regWrData,
  output logic [`AFEOGL_DATA_W-1:0] regRdData,
  output logic regRdValid,
  input wire logic [LANES-1:0] videoLane,
  output logic [LANES-1:0] laneOut,
  output afeogl_pkg::afeogl_buf_strength_t bufferStrength,
  output logic [3:0] converterBias,
  output logic [9:0] redOddOffset,
  output logic [9:0] redEvenOffset,
  output logic [9:0] greenOddOffset,
  output logic [9:0] greenEvenOffset,
  output logic [9:0] blueOddOffset,
  output logic [9:0] blueEvenOffset,
  output logic [1:0] redOddRangeSelect,
  output logic [1:0] redEvenRangeSelect,
  output logic [1:0] greenOddRangeSelect,
  output logic [1:0] greenEvenRangeSelect,
  output logic [1:0] blueOddRangeSelect,
  output logic [1:0] blueEvenRangeSelect,
  output logic [7:0] redOddGain,
  output logic [7:0] redEvenGain,
  output logic [7:0] greenOddGain,
  output logic [7:0] greenEvenGain,
  output logic [7:0] blueOddGain,
  output logic [7:0] blueEvenGain,
  output logic [LANES-1:0] laneEnable,
  output logic testPatternEnable,
  output logic outputEmphasisEnable
);

  localparam int NREGS = 14;
  localparam int IDX_MODE = 0;
  localparam int IDX_OFS0 = 1;
  localparam int IDX_LANE = 7;
  localparam int IDX_GAIN0 = 8;

  localparam logic [NREGS-1:0][7:0] REG_ADDR = {
    `AFEOGL_OFS_BLUE_EVEN_GAIN, `AFEOGL_OFS_BLUE_ODD_GAIN,
    `AFEOGL_OFS_GREEN_EVEN_GAIN, `AFEOGL_OFS_GREEN_ODD_GAIN,
    `AFEOGL_OFS_RED_EVEN_GAIN, `AFEOGL_OFS_RED_ODD_GAIN,
    `AFEOGL_OFS_LANE_CTRL,
    `AFEOGL_OFS_BLUE_EVEN_OFFSET, `AFEOGL_OFS_BLUE_ODD_OFFSET,
    `AFEOGL_OFS_GREEN_EVEN_OFFSET, `AFEOGL_OFS_GREEN_ODD_OFFSET,
    `AFEOGL_OFS_RED_EVEN_OFFSET, `AFEOGL_OFS_RED_ODD_OFFSET,
    `AFEOGL_OFS_CONV_MODE
  };

  // Reset and write-mask per register index
  function automatic afeogl_pkg::afeogl_word_t resetOf(input int idx);
    if (idx == IDX_MODE) begin
      return `AFEOGL_RST_CONV_MODE; // R01
    end else if (idx < IDX_LANE) begin
      return `AFEOGL_RST_OFFSET; // R03
    end else if (idx == IDX_LANE) begin
      return `AFEOGL_RST_LANE_CTRL; // R11
    end else begin
      return `AFEOGL_RST_GAIN; // R05
    end
  endfunction

  function automatic afeogl_pkg::afeogl_word_t maskOf(input int idx);
    if (idx == IDX_MODE) begin
      return `AFEOGL_MASK_CONV_MODE;
    end else if (idx < IDX_LANE) begin
      return `AFEOGL_MASK_OFFSET;
    end else if (idx == IDX_LANE) begin
      return `AFEOGL_MASK_LANE_CTRL;
    end else begin
      return `AFEOGL_MASK_GAIN;
    end
  endfunction

  afeogl_wr_if wrBus ();
  afeogl_pkg::afeogl_word_t regVal [NREGS];

  assign wrBus.wrStrobe = regWr;
  assign wrBus.wrAddr = regAddr;
  assign wrBus.wrData = regWrData;

  genvar gi;
  generate
    for (gi = 0; gi < NREGS; gi++) begin : gRegs
      afeogl_field_reg #(
        .ADDR(REG_ADDR[gi]),
        .RESET_VALUE(resetOf(gi)),
        .WRITE_MASK(maskOf(gi))
      ) uReg (
        .clk(clk),
        .rst(rst),
        .wr(wrBus),
        .value(regVal[gi])
      );
    end
  endgenerate

  // Register read: unmapped indices return zero
  logic [`AFEOGL_DATA_W-1:0] rdMux;
  always_comb begin
    rdMux = '0;
    for (int i = 0; i < NREGS; i++) begin
      if (regAddr == REG_ADDR[i]) begin
        rdMux = regVal[i]; // R10
      end
    end
  end

  logic [`AFEOGL_DATA_W-1:0] regRdData_q;
  logic regRdValid_q;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      regRdData_q <= '0;
      regRdValid_q <= 1'b0;
    end else begin
      regRdValid_q <= regRd;
      if (regRd) begin
        regRdData_q <= rdMux;
      end
    end
  end
  assign regRdData = regRdData_q;
  assign regRdValid = regRdValid_q;

  // Field views; every one is a slice of a register flop
  assign bufferStrength = afeogl_pkg::afeogl_buf_strength_t'(
    regVal[IDX_MODE][`AFEOGL_BUF_STRENGTH_HI:`AFEOGL_BUF_STRENGTH_LO]); // R01
  assign converterBias = regVal[IDX_MODE][`AFEOGL_BIAS_HI:`AFEOGL_BIAS_LO];
  assign redOddOffset = regVal[IDX_OFS0]; // R03
  assign redEvenOffset = regVal[IDX_OFS0+1];
  assign greenOddOffset = regVal[IDX_OFS0+2];
  assign greenEvenOffset = regVal[IDX_OFS0+3];
  assign blueOddOffset = regVal[IDX_OFS0+4];
  assign blueEvenOffset = regVal[IDX_OFS0+5];
  assign redOddRangeSelect = regVal[IDX_GAIN0][`AFEOGL_RANGE_HI:`AFEOGL_RANGE_LO]; // R05
  assign redEvenRangeSelect = regVal[IDX_GAIN0+1][`AFEOGL_RANGE_HI:`AFEOGL_RANGE_LO];
  assign greenOddRangeSelect = regVal[IDX_GAIN0+2][`AFEOGL_RANGE_HI:`AFEOGL_RANGE_LO];
  assign greenEvenRangeSelect = regVal[IDX_GAIN0+3][`AFEOGL_RANGE_HI:`AFEOGL_RANGE_LO];
  assign blueOddRangeSelect = regVal[IDX_GAIN0+4][`AFEOGL_RANGE_HI:`AFEOGL_RANGE_LO];
  assign blueEvenRangeSelect = regVal[IDX_GAIN0+5][`AFEOGL_RANGE_HI:`AFEOGL_RANGE_LO];
  assign redOddGain = regVal[IDX_GAIN0][`AFEOGL_GAIN_HI:`AFEOGL_GAIN_LO];
  assign redEvenGain = regVal[IDX_GAIN0+1][`AFEOGL_GAIN_HI:`AFEOGL_GAIN_LO];
  assign greenOddGain = regVal[IDX_GAIN0+2][`AFEOGL_GAIN_HI:`AFEOGL_GAIN_LO];
  assign greenEvenGain = regVal[IDX_GAIN0+3][`AFEOGL_GAIN_HI:`AFEOGL_GAIN_LO];
  assign blueOddGain = regVal[IDX_GAIN0+4][`AFEOGL_GAIN_HI:`AFEOGL_GAIN_LO];
  assign blueEvenGain = regVal[IDX_GAIN0+5][`AFEOGL_GAIN_HI:`AFEOGL_GAIN_LO];
  assign laneEnable = regVal[IDX_LANE][`AFEOGL_LANE_EN_HI:`AFEOGL_LANE_EN_LO];
  assign testPatternEnable = regVal[IDX_LANE][`AFEOGL_TEST_PATTERN_BIT];
  assign outputEmphasisEnable = regVal[IDX_LANE][`AFEOGL_EMPHASIS_BIT]; // R09

  // Test code: alternating pattern, inverted every clock
  logic [LANES-1:0] pattern_q;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pattern_q <= LANES'(`AFEOGL_TEST_PATTERN_SEED);
    end else begin
      pattern_q <= ~pattern_q;
    end
  end

  // Lane output: source select, then per-lane enable gate
  logic [LANES-1:0] laneOut_q;
  logic [LANES-1:0] laneOut_d;
  always_comb begin
    laneOut_d = testPatternEnable ? pattern_q : videoLane; // R08
    laneOut_d = laneOut_d & laneEnable; // R07
  end
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      laneOut_q <= '0;
    end else begin
      laneOut_q <= laneOut_d;
    end
  end
  assign laneOut = laneOut_q;

endmodule // afe_offset_gain_lvds_regs

// file: afeogl_regs_props.sv
// Purpose: Port-level timing checks of the setting bank
// Assumes: One clock, asynchronous active-high reset
// Notes: Bound into the bank after endmodule
`timescale 1ns/100ps
module afeogl_regs_props #(
  parameter int LANES = 5
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic regWr,
  input wire logic regRd,
  input wire logic [7:0] regAddr,
  input wire logic [9:0] regWrData,
  input wire logic regRdValid,
  input wire logic [LANES-1:0] videoLane,
  input wire logic [LANES-1:0] laneOut,
  input wire afeogl_pkg::afeogl_buf_strength_t bufferStrength,
  input wire logic [3:0] converterBias,
  input wire logic [9:0] redOddOffset,
  input wire logic [1:0] blueEvenRangeSelect,
  input wire logic [7:0] blueEvenGain,
  input wire logic [LANES-1:0] laneEnable,
  input wire logic testPatternEnable,
  input wire logic outputEmphasisEnable
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  a_rd_answer: assert property (regRd |=> regRdValid)
    else $error("read strobe not answered");
  a_mode_write: assert property (regWr && regAddr == 8'h0F |=>
    bufferStrength == $past(regWrData[7:6]) && converterBias == $past(regWrData[3:0]))
    else $error("mode fields differ from write");
  a_offset_write: assert property (regWr && regAddr == 8'h10 |=> redOddOffset == $past(regWrData))
    else $error("offset differs from write");
  a_gain_write: assert property (regWr && regAddr == 8'h1D |=>
    {blueEvenRangeSelect, blueEvenGain} == $past(regWrData))
    else $error("gain fields differ from write");
  a_lane_write: assert property (regWr && regAddr == 8'h16 |=> laneEnable == $past(regWrData[8:4])
    && testPatternEnable == $past(regWrData[2]) && outputEmphasisEnable == $past(regWrData[0]))
    else $error("lane control differs from write");
  a_lane_hold: assert property (!(regWr && regAddr == 8'h16) |=>
    $stable({laneEnable, testPatternEnable, outputEmphasisEnable}))
    else $error("lane control moved without write");
  a_lane_video: assert property (!$past(rst) && !$past(testPatternEnable) |->
    laneOut == ($past(videoLane) & $past(laneEnable)))
    else $error("lane output not masked video");
  a_pattern_flip: assert property (!$past(rst) && !$past(rst, 2) && $past(testPatternEnable)
    && $past(testPatternEnable, 2) && $past(laneEnable) == $past(laneEnable, 2)
    |-> laneOut == (~$past(laneOut) & $past(laneEnable)))
    else $error("test pattern did not toggle");
  c_lanes_off: cover property (laneEnable == 5'h00);
  c_pattern: cover property (testPatternEnable);
  c_unmapped: cover property (regWr && regAddr == 8'h17);
endmodule // afeogl_regs_props

bind afe_offset_gain_lvds_regs afeogl_regs_props #(.LANES(LANES)) afeogl_regs_props_inst (.*);

// file: afeogl_host_model.sv
// Purpose: Host controller model driving the setting bank strobes
// Assumes: Strobes launched just after a rising edge
// Notes: One idle cycle between accesses
`timescale 1ns/100ps
module afeogl_host_model (
  input wire logic clk,
  output logic regWr,
  output logic regRd,
  output logic [7:0] regAddr,
  output logic [9:0] regWrData
);
  initial begin
    regWr = 1'b0;
    regRd = 1'b0;
    regAddr = 8'h00;
    regWrData = 10'h000;
  end
  task automatic wr(input logic [7:0] ad, input logic [9:0] d);
    @(posedge clk);
    regWr <= 1'b1;
    regAddr <= ad;
    regWrData <= (ad >= 8'h18) ? (d & 10'h3FE) : d;
    @(posedge clk);
    regWr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] ad);
    @(posedge clk);
    regRd <= 1'b1;
    regAddr <= ad;
    @(posedge clk);
    regRd <= 1'b0;
  endtask
endmodule // afeogl_host_model

// file: test_afe_offset_gain_lvds_regs.sv
// Purpose: Self-checking bench of the setting bank
// Assumes: Host model drives the register strobes
// Notes: Read results are queued and checked on regRdValid
`timescale 1ns/100ps
module test_afe_offset_gain_lvds_regs;
  logic clk;
  logic rst;
  logic regWr, regRd, regRdValid;
  logic [7:0] regAddr;
  logic [9:0] regWrData, regRdData, v;
  logic [4:0] videoLane, laneOut, laneEnable, a;
  int mismatches, checked, seed;
  logic [9:0] q[$];
  afeogl_pkg::afeogl_buf_strength_t bufferStrength;
  logic [3:0] converterBias;
  logic [9:0] redOddOffset, redEvenOffset, greenOddOffset, greenEvenOffset, blueOddOffset, blueEvenOffset;
  logic [1:0] redOddRangeSelect, redEvenRangeSelect, greenOddRangeSelect;
  logic [1:0] greenEvenRangeSelect, blueOddRangeSelect, blueEvenRangeSelect;
  logic [7:0] redOddGain, redEvenGain, greenOddGain, greenEvenGain, blueOddGain, blueEvenGain;
  logic testPatternEnable, outputEmphasisEnable;
  afe_offset_gain_lvds_regs afe_offset_gain_lvds_regs_inst (.*);
  afeogl_host_model afeogl_host_model_inst (.*);
  function automatic logic [9:0] rstv(input logic [7:0] ad);
    if (ad == 8'h0F) return 10'h049;
    if (ad == 8'h16) return 10'h1F0;
    if (ad == 8'h17) return 10'h000;
    return (ad < 8'h16) ? 10'h200 : 10'h09F;
  endfunction
  function automatic logic [9:0] mask(input logic [7:0] ad);
    if (ad == 8'h0F) return 10'h0CF;
    if (ad == 8'h16) return 10'h1F5;
    if (ad == 8'h17) return 10'h000;
    return (ad >= 8'h18) ? 10'h3FE : 10'h3FF;
  endfunction
  // Field outputs gathered back into register layout
  function automatic logic [9:0] fld(input logic [7:0] ad);
    case (ad)
      8'h0F: return {2'b00, bufferStrength, 2'b00, converterBias};
      8'h10: return redOddOffset;
      8'h11: return redEvenOffset;
      8'h12: return greenOddOffset;
      8'h13: return greenEvenOffset;
      8'h14: return blueOddOffset;
      8'h15: return blueEvenOffset;
      8'h16: return {1'b0, laneEnable, 1'b0, testPatternEnable, 1'b0, outputEmphasisEnable};
      8'h18: return {redOddRangeSelect, redOddGain};
      8'h19: return {redEvenRangeSelect, redEvenGain};
      8'h1A: return {greenOddRangeSelect, greenOddGain};
      8'h1B: return {greenEvenRangeSelect, greenEvenGain};
      8'h1C: return {blueOddRangeSelect, blueOddGain};
      8'h1D: return {blueEvenRangeSelect, blueEvenGain};
      default: return 10'h000;
    endcase
  endfunction
  task automatic cmp(input logic [9:0] g, input logic [9:0] e);
    checked++;
    if (g !== e) begin
      mismatches++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic rdc(input logic [7:0] ad, input logic [9:0] e);
    q.push_back(e);
    afeogl_host_model_inst.rd(ad);
  endtask
  task automatic report_and_stop;
    // A read that was never answered counts against the run
    if (q.size() != 0) mismatches++;
    if (mismatches == 0 && checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  always @(negedge clk) begin
    if (regRdValid === 1'b1) cmp(regRdData, q.pop_front());
  end
  initial begin
    seed = 70;
    rst = 1'b1;
    videoLane = 5'h00;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    for (int ad = 15; ad <= 29; ad++) begin
      rdc(8'(ad), rstv(8'(ad)));
      cmp(fld(8'(ad)), rstv(8'(ad)));
    end
    for (int i = 0; i < 4; i++) begin
      afeogl_host_model_inst.wr(8'h0F, {2'b11, 2'(i), 2'b11, 4'hD});
      rdc(8'h0F, {2'b00, 2'(i), 2'b00, 4'hD});
    end
    for (int ad = 15; ad <= 29; ad++) begin
      v = 10'($random(seed));
      afeogl_host_model_inst.wr(8'(ad), v);
      rdc(8'(ad), v & mask(8'(ad)));
      cmp(fld(8'(ad)), v & mask(8'(ad)));
    end
    for (int i = 0; i < 4; i++) begin
      a = (i == 0) ? 5'h00 : 5'($random(seed));
      @(posedge clk);
      videoLane <= 5'($random(seed));
      afeogl_host_model_inst.wr(8'h16, {1'b0, a, 4'h0});
      repeat (3) @(negedge clk);
      cmp(10'(laneOut), 10'(videoLane & a));
    end
    afeogl_host_model_inst.wr(8'h16, 10'h3FF);
    rdc(8'h16, 10'h1F5);
    repeat (3) @(negedge clk);
    a = laneOut;
    @(negedge clk);
    cmp(10'(laneOut), {5'h00, ~a});
    repeat (4) @(posedge clk);
    report_and_stop();
  end
  initial begin
    #20000;
    mismatches++;
    report_and_stop();
  end
endmodule // test_afe_offset_gain_lvds_regs
